/* oms_pkg.sv */
// package: constants, register map and types for the operating mode selector
package oms_pkg;

  localparam int unsigned OMS_CLK_KHZ = 10000;
  localparam int unsigned OMS_LONG_MS = 2000;
  localparam int unsigned OMS_TMO_MS = 10000;
  localparam int unsigned OMS_BLINK_MS = 250;
  localparam int unsigned OMS_DEB_MS = 10;
  localparam int unsigned OMS_LONG_CYC = OMS_LONG_MS * OMS_CLK_KHZ;
  localparam int unsigned OMS_TMO_CYC = OMS_TMO_MS * OMS_CLK_KHZ;
  localparam int unsigned OMS_BLINK_CYC = OMS_BLINK_MS * OMS_CLK_KHZ;
  localparam int unsigned OMS_DEB_CYC = OMS_DEB_MS * OMS_CLK_KHZ;

  localparam int unsigned OMS_LEVEL_W = 4;
  localparam int unsigned OMS_GREEN_MIN = 6;

  localparam logic [3:0] OMS_REG_STATUS = 4'h0;
  localparam logic [3:0] OMS_REG_CONTROL = 4'h4;
  localparam logic [3:0] OMS_REG_LOSS = 4'h8;

  localparam int unsigned OMS_ST_ACTIVE_LSB = 0;
  localparam int unsigned OMS_ST_PENDING_LSB = 4;
  localparam int unsigned OMS_ST_SEL_LSB = 8;
  localparam int unsigned OMS_ST_TX_BIT = 12;
  localparam int unsigned OMS_ST_LATCH_BIT = 13;
  localparam int unsigned OMS_ST_FITTED_BIT = 14;
  localparam int unsigned OMS_ST_LINKCMD_BIT = 15;
  localparam int unsigned OMS_CTRL_SOFTBTN_BIT = 0;
  localparam logic OMS_CTRL_RESET = 1'b0;
  localparam logic [15:0] OMS_LOSS_MAX = 16'hFFFF;

  typedef enum logic [2:0] {
    OMS_RUN,
    OMS_HAND,
    OMS_MIRROR,
    OMS_BEAM,
    OMS_DROP
  } oms_mode_e;

  typedef enum logic [1:0] {
    OMS_SEL_IDLE,
    OMS_SEL_PICK,
    OMS_SEL_ARMED
  } oms_sel_e;

endpackage

/* oms_debounce.sv */
// button synchroniser and debouncer
`timescale 1ns/1ps
module oms_debounce
  import oms_pkg::*;
#(
  parameter int unsigned DEB_CYC = OMS_DEB_CYC
)(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_raw,
  output logic o_level
);

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic level;
    logic [31:0] cnt;
  } oms_deb_s;

  oms_deb_s st;
  oms_deb_s next_st;

  // level only follows after the synchronised input has been steady for DEB_CYC
  always_comb
  begin
    next_st = st;
    next_st.sync1 = i_raw;
    next_st.sync2 = st.sync1;
    if (st.sync2 != st.level)
    begin
      if (st.cnt >= DEB_CYC - 1)
      begin
        next_st.level = st.sync2;
        next_st.cnt = '0;
      end
      else
      begin
        next_st.cnt = st.cnt + 32'h00000001;
      end
    end
    else
    begin
      next_st.cnt = '0;
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign o_level = st.level;

endmodule

/* oms_mode_selector.sv */
// operating mode selector: button sequencing, mode outputs and avalon register slave
`timescale 1ns/1ps
module oms_mode_selector
  import oms_pkg::*;
#(
  parameter int unsigned LEVEL_W = OMS_LEVEL_W,
  parameter int unsigned GREEN_MIN = OMS_GREEN_MIN,
  parameter int unsigned LONG_CYC = OMS_LONG_CYC,
  parameter int unsigned TMO_CYC = OMS_TMO_CYC,
  parameter int unsigned BLINK_CYC = OMS_BLINK_CYC,
  parameter int unsigned DEB_CYC = OMS_DEB_CYC
)(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_button,
  input wire logic i_laser_fitted,
  input wire logic i_link_ok,
  input wire logic [LEVEL_W-1:0] i_local_level,
  input wire logic [LEVEL_W-1:0] i_remote_level,
  input wire logic i_peer_hand,
  input wire logic i_peer_mirror_cmd,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_tx_enable,
  output logic [LEVEL_W-1:0] o_gauge_level,
  output logic o_led_run,
  output logic o_led_hand,
  output logic o_led_mirror,
  output logic o_led_beam,
  output logic o_led_drop_green,
  output logic o_led_drop_red,
  output logic o_laser_on,
  output logic o_hand_active,
  output logic o_mirror_cmd
);

  typedef struct packed {
    oms_mode_e active;
    oms_mode_e pending;
    oms_sel_e sel;
    logic [31:0] hold_cnt;
    logic [31:0] idle_cnt;
    logic [31:0] blink_cnt;
    logic blink;
    logic strap_done;
    logic fitted;
    logic latch;
    logic link_prev;
    logic [15:0] loss_cnt;
    logic mirror_link;
    logic peer_cmd_prev;
    logic press_prev;
    logic ctrl_soft;
    logic avs_wait;
    logic [31:0] rdata;
    logic tx;
    logic [LEVEL_W-1:0] gauge;
    logic led_run;
    logic led_hand;
    logic led_mirror;
    logic led_beam;
    logic led_drop_g;
    logic led_drop_r;
    logic laser;
    logic hand_act;
  } oms_state_s;

  oms_state_s st;
  oms_state_s next_st;
  logic deb_button;
  logic press;
  logic commit;
  logic show;
  logic [31:0] status;
  oms_mode_e na;

  oms_debounce #(
    .DEB_CYC(DEB_CYC)
  ) u_debounce (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_raw(i_button),
    .o_level(deb_button)
  );

  // variants without a laser skip the pointer beam step
  function automatic oms_mode_e oms_next(input oms_mode_e m, input logic fit);
    oms_mode_e r;
    r = OMS_RUN;
    case (m)
      OMS_RUN: r = OMS_HAND;
      OMS_HAND: r = OMS_MIRROR;
      OMS_MIRROR: r = fit ? OMS_BEAM : OMS_DROP;
      OMS_BEAM: r = OMS_DROP;
      OMS_DROP: r = OMS_RUN;
      default: r = OMS_RUN;
    endcase
    return r;
  endfunction

  always_comb
  begin
    next_st = st;
    commit = 1'b0;
    show = 1'b0;
    status = '0;
    na = st.active;
    press = deb_button | st.ctrl_soft;
    next_st.press_prev = press;

    // strap sampled once, after reset release
    if (!st.strap_done)
    begin
      next_st.fitted = i_laser_fitted;
      next_st.strap_done = 1'b1;
    end

    if (st.blink_cnt >= BLINK_CYC - 1)
    begin
      next_st.blink_cnt = '0;
      next_st.blink = ~st.blink;
    end
    else
    begin
      next_st.blink_cnt = st.blink_cnt + 32'h00000001;
    end

    // selection sequence; a long hold from idle is ignored, nothing is pending
    case (st.sel)
      OMS_SEL_IDLE:
      begin
        if (press)
        begin
          if (st.hold_cnt < LONG_CYC)
          begin
            next_st.hold_cnt = st.hold_cnt + 32'h00000001;
          end
        end
        else
        begin
          next_st.hold_cnt = '0;
          if (st.press_prev && st.hold_cnt < LONG_CYC)
          begin
            next_st.pending = oms_next(st.active, st.fitted);
            next_st.sel = OMS_SEL_PICK;
            next_st.idle_cnt = '0;
          end
        end
      end
      OMS_SEL_PICK:
      begin
        if (press)
        begin
          next_st.idle_cnt = '0;
          if (st.hold_cnt >= LONG_CYC - 1)
          begin
            next_st.sel = OMS_SEL_ARMED;
            next_st.hold_cnt = '0;
          end
          else
          begin
            next_st.hold_cnt = st.hold_cnt + 32'h00000001;
          end
        end
        else
        begin
          next_st.hold_cnt = '0;
          if (st.press_prev)
          begin
            next_st.pending = oms_next(st.pending, st.fitted);
            next_st.idle_cnt = '0;
          end
          else if (st.idle_cnt >= TMO_CYC - 1)
          begin
            next_st.sel = OMS_SEL_IDLE;
          end
          else
          begin
            next_st.idle_cnt = st.idle_cnt + 32'h00000001;
          end
        end
      end
      OMS_SEL_ARMED:
      begin
        if (!press)
        begin
          commit = 1'b1;
          next_st.sel = OMS_SEL_IDLE;
        end
      end
      default:
      begin
        next_st.sel = OMS_SEL_IDLE;
      end
    endcase

    // one active mode at a time, so committing replaces the old one
    if (commit)
    begin
      next_st.active = st.pending;
      next_st.mirror_link = (st.pending == OMS_MIRROR) && (st.active == OMS_HAND)
        && i_peer_hand;
      if (st.pending == OMS_DROP)
      begin
        next_st.latch = 1'b0;
      end
    end
    else if (st.active == OMS_HAND && i_peer_mirror_cmd && !st.peer_cmd_prev)
    begin
      next_st.active = OMS_MIRROR;
      next_st.mirror_link = 1'b0;
    end
    next_st.peer_cmd_prev = i_peer_mirror_cmd;
    na = next_st.active;
    if (na != OMS_MIRROR)
    begin
      next_st.mirror_link = 1'b0;
    end

    // link loss sets after the recommit clear, so a loss in that cycle is kept
    next_st.link_prev = i_link_ok;
    if (na == OMS_DROP)
    begin
      if (!i_link_ok)
      begin
        next_st.latch = 1'b1;
      end
      if (st.link_prev && !i_link_ok && st.loss_cnt != OMS_LOSS_MAX)
      begin
        next_st.loss_cnt = st.loss_cnt + 16'h0001;
      end
    end
    else
    begin
      next_st.latch = 1'b0;
    end

    // transmission follows the active mode and, in hand tuning, the local level; never the pending one
    next_st.tx = (na != OMS_MIRROR)
      && !(na == OMS_HAND && i_local_level < LEVEL_W'(GREEN_MIN));
    next_st.gauge = (na == OMS_MIRROR) ? i_remote_level : i_local_level;
    next_st.laser = (na == OMS_BEAM);

    next_st.led_run = (na == OMS_RUN) || (na == OMS_BEAM) || (na == OMS_DROP);
    next_st.led_hand = (na == OMS_HAND);
    next_st.led_mirror = (na == OMS_MIRROR);
    next_st.led_beam = (na == OMS_BEAM);
    next_st.led_drop_g = (na == OMS_DROP) && !next_st.latch;
    next_st.led_drop_r = (na == OMS_DROP) && next_st.latch;

    // pending indicator overrides its own lamp: flashing, then steady once armed
    if (next_st.sel != OMS_SEL_IDLE)
    begin
      show = (next_st.sel == OMS_SEL_ARMED) || st.blink;
      case (next_st.pending)
        OMS_RUN: next_st.led_run = show;
        OMS_HAND: next_st.led_hand = show;
        OMS_MIRROR: next_st.led_mirror = show;
        OMS_BEAM: next_st.led_beam = show;
        OMS_DROP:
        begin
          next_st.led_drop_g = show;
          next_st.led_drop_r = 1'b0;
        end
        default: next_st.led_run = next_st.led_run;
      endcase
    end

    // registered so the output comes straight from a flop, after the overlay is known
    next_st.hand_act = next_st.led_hand && (na == OMS_HAND);

    // avalon slave: one wait cycle, then the answer; write lands as waitrequest is low
    status[OMS_ST_ACTIVE_LSB +: 3] = st.active;
    status[OMS_ST_PENDING_LSB +: 3] = st.pending;
    status[OMS_ST_SEL_LSB +: 2] = st.sel;
    status[OMS_ST_TX_BIT] = st.tx;
    status[OMS_ST_LATCH_BIT] = st.latch;
    status[OMS_ST_FITTED_BIT] = st.fitted;
    status[OMS_ST_LINKCMD_BIT] = st.mirror_link;
    next_st.avs_wait = 1'b1;
    if ((i_avs_read || i_avs_write) && st.avs_wait)
    begin
      next_st.avs_wait = 1'b0;
      if (i_avs_read)
      begin
        case ({i_avs_address[3:2], 2'b00})
          OMS_REG_STATUS: next_st.rdata = status;
          OMS_REG_CONTROL: next_st.rdata = {31'h00000000, st.ctrl_soft};
          OMS_REG_LOSS: next_st.rdata = {16'h0000, st.loss_cnt};
          default: next_st.rdata = '0;
        endcase
      end
    end
    if (i_avs_write && !st.avs_wait && {i_avs_address[3:2], 2'b00} == OMS_REG_CONTROL)
    begin
      next_st.ctrl_soft = i_avs_writedata[OMS_CTRL_SOFTBTN_BIT];
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      st <= '0;
      st.active <= OMS_RUN;
      st.sel <= OMS_SEL_IDLE;
      st.ctrl_soft <= OMS_CTRL_RESET;
      st.avs_wait <= 1'b1;
      st.tx <= 1'b1;
      st.led_run <= 1'b1;
      st.link_prev <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign o_avs_readdata = st.rdata;
  assign o_avs_waitrequest = st.avs_wait;
  assign o_tx_enable = st.tx;
  assign o_gauge_level = st.gauge;
  assign o_led_run = st.led_run;
  assign o_led_hand = st.led_hand;
  assign o_led_mirror = st.led_mirror;
  assign o_led_beam = st.led_beam;
  assign o_led_drop_green = st.led_drop_g;
  assign o_led_drop_red = st.led_drop_r;
  assign o_laser_on = st.laser;
  assign o_hand_active = st.hand_act;
  assign o_mirror_cmd = st.mirror_link;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  a_reset_run: assert property ($past(i_rst) |-> st.active == OMS_RUN && o_tx_enable)
    else $error("mode after reset is not normal run");
  a_hand_tx_stop: assert property (
    st.active == OMS_HAND && $past(i_local_level) < LEVEL_W'(GREEN_MIN) |-> !o_tx_enable)
    else $error("hand tuning kept transmitting without green level");
  a_hand_run_off: assert property (
    st.active == OMS_HAND && st.sel == OMS_SEL_IDLE |-> !o_led_run && o_led_hand)
    else $error("run indicator lit in hand tuning");
  a_mirror_outputs: assert property (
    st.active == OMS_MIRROR |-> !o_tx_enable && o_gauge_level == $past(i_remote_level))
    else $error("mirror mode transmits or shows local level");
  a_mirror_leds: assert property (
    st.active == OMS_MIRROR && st.sel == OMS_SEL_IDLE |-> !o_led_run && !o_led_hand)
    else $error("run or hand indicator lit in mirror mode");
  a_beam_fitted: assert property (st.active == OMS_BEAM |-> st.fitted && o_tx_enable)
    else $error("pointer beam active without laser or without transmission");
  a_beam_leds: assert property (
    st.active == OMS_BEAM && st.sel == OMS_SEL_IDLE |-> o_led_run && o_led_beam && o_laser_on)
    else $error("pointer beam indicators wrong");
  a_drop_red: assert property (
    st.active == OMS_DROP && st.sel == OMS_SEL_IDLE && !i_link_ok |=> o_led_drop_red)
    else $error("link loss not shown in dropout latch mode");
  a_drop_hold: assert property (
    st.latch && st.active == OMS_DROP && !(st.sel == OMS_SEL_ARMED && !press) |=> st.latch)
    else $error("dropout latch released without recommit");
  a_drop_leds: assert property (
    st.active == OMS_DROP && st.sel == OMS_SEL_IDLE |-> o_led_run
      && (o_led_drop_green != o_led_drop_red))
    else $error("dropout indicators wrong");
  a_long_armed: assert property (
    st.sel == OMS_SEL_PICK && press && st.hold_cnt >= LONG_CYC - 1 |=> st.sel == OMS_SEL_ARMED)
    else $error("long hold did not arm the selection");
  a_commit_release: assert property (
    st.sel == OMS_SEL_ARMED && !press |=> st.active == $past(st.pending) && st.sel == OMS_SEL_IDLE)
    else $error("release did not commit pending mode");
  a_select_timeout: assert property (
    st.sel == OMS_SEL_PICK && !press && !st.press_prev && st.idle_cnt >= TMO_CYC - 1
      && st.active != OMS_HAND |=> st.sel == OMS_SEL_IDLE && $stable(st.active))
    else $error("stale selection not abandoned");
  a_peer_follow: assert property (
    st.active == OMS_HAND && st.sel != OMS_SEL_ARMED && i_peer_mirror_cmd && !st.peer_cmd_prev
      |=> st.active == OMS_MIRROR)
    else $error("did not follow opposing unit into mirror mode");

  c_commit_hand: cover property (st.sel == OMS_SEL_ARMED && !press ##1 st.active == OMS_HAND);
  c_drop_latched: cover property (st.active == OMS_DROP && st.latch ##1 i_link_ok);
  c_timeout: cover property (st.sel == OMS_SEL_PICK ##1 st.sel == OMS_SEL_IDLE
    && st.active == $past(st.active));
  c_peer_mirror: cover property (st.active == OMS_HAND ##1 st.active == OMS_MIRROR);

endmodule

/* oms_peer_model.sv */
// partner model: opposing transceiver link status, level and mode handshake
`timescale 1ns/1ps
module oms_peer_model #(
  parameter int unsigned LEVEL_W = 4
)(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_mirror_cmd,
  input wire logic i_want_hand,
  input wire logic i_want_mirror,
  input wire logic i_cut_link,
  input wire logic [LEVEL_W-1:0] i_level,
  output logic o_link_ok,
  output logic [LEVEL_W-1:0] o_remote_level,
  output logic o_peer_hand,
  output logic o_peer_mirror_cmd
);
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      o_link_ok <= 1'b1;
      o_remote_level <= '0;
      o_peer_hand <= 1'b0;
      o_peer_mirror_cmd <= 1'b0;
    end
    else
    begin
      o_link_ok <= !i_cut_link;
      o_remote_level <= i_level;
      // peer leaves hand tuning when pulled into mirror, or while pulling us
      o_peer_hand <= i_want_hand && !i_mirror_cmd && !o_peer_mirror_cmd;
      o_peer_mirror_cmd <= i_want_mirror && o_peer_hand;
    end
  end
endmodule

/* test_operating_mode_selector.sv */
// self-checking testbench for the operating mode selector
`timescale 1ns/1ps
module test_operating_mode_selector;
  import oms_pkg::*;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic i_button = 1'b0;
  logic i_laser_fitted = 1'b1;
  logic [3:0] i_local_level = 4'h9;
  logic [3:0] av_addr = 4'h0;
  logic av_read = 1'b0;
  logic av_write = 1'b0;
  logic [31:0] av_wdata = 32'h0;
  logic want_hand = 1'b0;
  logic want_mirror = 1'b0;
  logic cut = 1'b0;
  logic [3:0] far_level = 4'h3;
  wire [31:0] av_rdata;
  wire av_wait, tx, mcmd, link_ok, peer_hand, peer_cmd, hand_act;
  wire [3:0] gauge, rlevel;
  wire [6:0] leds;
  logic [31:0] st;
  int n_fail = 0;
  int checks_done = 0;

  always #50 i_clk_sys = ~i_clk_sys;

  // short counts keep the run small; expectations use the same figures
  oms_mode_selector #(.LONG_CYC(20), .TMO_CYC(200), .BLINK_CYC(4), .DEB_CYC(3)) u_dut (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_button(i_button),
    .i_laser_fitted(i_laser_fitted), .i_link_ok(link_ok), .i_local_level(i_local_level),
    .i_remote_level(rlevel), .i_peer_hand(peer_hand), .i_peer_mirror_cmd(peer_cmd),
    .i_avs_address(av_addr), .i_avs_read(av_read), .i_avs_write(av_write),
    .i_avs_writedata(av_wdata), .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait),
    .o_tx_enable(tx), .o_gauge_level(gauge), .o_led_run(leds[6]), .o_led_hand(leds[5]),
    .o_led_mirror(leds[4]), .o_led_beam(leds[3]), .o_led_drop_green(leds[2]),
    .o_led_drop_red(leds[1]), .o_laser_on(leds[0]), .o_hand_active(hand_act),
    .o_mirror_cmd(mcmd)
  );

  oms_peer_model #(.LEVEL_W(4)) u_peer (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_mirror_cmd(mcmd), .i_want_hand(want_hand),
    .i_want_mirror(want_mirror), .i_cut_link(cut), .i_level(far_level),
    .o_link_ok(link_ok), .o_remote_level(rlevel), .o_peer_hand(peer_hand),
    .o_peer_mirror_cmd(peer_cmd)
  );

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask

  // request stands until the rising edge that samples waitrequest low; data taken there
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk_sys);
    av_addr <= a;
    av_wdata <= d;
    av_write <= wr;
    av_read <= !wr;
    n = 0;
    do
    begin
      @(posedge i_clk_sys);
      n++;
    end
    while (av_wait !== 1'b0 && n < 50);
    st = av_rdata;
    av_read <= 1'b0;
    av_write <= 1'b0;
    if (av_wait !== 1'b0)
    begin
      chk("bus answer timeout", 32'h0, 32'h1);
      wrap_up;
    end
  endtask

  task automatic press(input int n);
    repeat (n)
    begin
      av(1'b1, OMS_REG_CONTROL, 32'h1);
      av(1'b1, OMS_REG_CONTROL, 32'h0);
      cyc(2);
    end
  endtask

  task automatic commit(input int n, input logic [2:0] m);
    press(n);
    av(1'b1, OMS_REG_CONTROL, 32'h1);
    cyc(25);
    av(1'b0, OMS_REG_STATUS, 32'h0);
    chk("selection steady", 32'h2, {30'h0, st[9:8]});
    av(1'b1, OMS_REG_CONTROL, 32'h0);
    cyc(2);
    av(1'b0, OMS_REG_STATUS, 32'h0);
    chk("active mode", {29'h0, m}, {29'h0, st[2:0]});
  endtask

  task automatic lamps(input logic [6:0] exp);
    @(negedge i_clk_sys);
    chk("lamps", {25'h0, exp}, {25'h0, leds});
  endtask

  task automatic reset_dut(input logic f);
    @(posedge i_clk_sys);
    i_rst <= 1'b1;
    i_laser_fitted <= f;
    cyc(3);
    i_rst <= 1'b0;
  endtask

  initial
  begin
    cyc(30000);
    chk("run time limit", 32'h0, 32'h1);
    wrap_up;
  end

  initial
  begin
    reset_dut(1'b1);
    av(1'b0, OMS_REG_STATUS, 32'h0);
    chk("mode after reset", 32'h0, {29'h0, st[2:0]});
    chk("tx after reset", 32'h1, {31'h0, st[12]});
    lamps(7'b1000000);
    av(1'b0, 4'hC, 32'h0);
    chk("unmapped read", 32'h0, st);
    $display("test reset finished");
    for (int i = 0; i < 5; i++)
    begin
      press(1);
      av(1'b0, OMS_REG_STATUS, 32'h0);
      chk("pending mode", (i + 1) % 5, {29'h0, st[6:4]});
      chk("selection flashing", 32'h1, {30'h0, st[9:8]});
      chk("tx while selecting", 32'h1, {31'h0, st[12]});
    end
    cyc(220);
    av(1'b0, OMS_REG_STATUS, 32'h0);
    chk("selection abandoned", 32'h0, {30'h0, st[9:8]});
    chk("mode kept", 32'h0, {29'h0, st[2:0]});
    $display("test walk finished");
    commit(1, OMS_HAND);
    lamps(7'b0100000);
    chk("hand active", 32'h1, {31'h0, hand_act});
    @(posedge i_clk_sys);
    i_local_level <= 4'h5;
    cyc(3);
    lamps(7'b0100000);
    chk("tx below green", 32'h0, {31'h0, tx});
    @(posedge i_clk_sys);
    i_local_level <= 4'h6;
    want_hand <= 1'b1;
    cyc(3);
    lamps(7'b0100000);
    chk("tx at green", 32'h1, {31'h0, tx});
    commit(1, OMS_MIRROR);
    lamps(7'b0010000);
    chk("tx in mirror", 32'h0, {31'h0, tx});
    chk("peer pulled", 32'h1, {31'h0, mcmd});
    chk("hand active in mirror", 32'h0, {31'h0, hand_act});
    chk("gauge remote", 32'h3, {28'h0, gauge});
    commit(4, OMS_HAND);
    @(posedge i_clk_sys);
    want_mirror <= 1'b1;
    cyc(5);
    av(1'b0, OMS_REG_STATUS, 32'h0);
    chk("pulled by peer", 32'h2, {29'h0, st[2:0]});
    want_mirror <= 1'b0;
    want_hand <= 1'b0;
    $display("test mirror finished");
    commit(1, OMS_BEAM);
    lamps(7'b1001001);
    chk("tx in beam", 32'h1, {31'h0, tx});
    commit(1, OMS_DROP);
    lamps(7'b1000100);
    @(posedge i_clk_sys);
    cut <= 1'b1;
    cyc(3);
    cut <= 1'b0;
    cyc(4);
    lamps(7'b1000010);
    av(1'b0, OMS_REG_STATUS, 32'h0);
    chk("latch held", 32'h1, {31'h0, st[13]});
    av(1'b0, OMS_REG_LOSS, 32'h0);
    chk("loss count", 32'h1, st);
    commit(5, OMS_DROP);
    lamps(7'b1000100);
    $display("test drop finished");
    reset_dut(1'b0);
    av(1'b0, OMS_REG_STATUS, 32'h0);
    chk("mode after reset", 32'h0, {29'h0, st[2:0]});
    chk("no laser strap", 32'h0, {31'h0, st[14]});
    press(3);
    av(1'b0, OMS_REG_STATUS, 32'h0);
    chk("beam skipped", 32'h4, {29'h0, st[6:4]});
    cyc(220);
    @(posedge i_clk_sys);
    i_button <= 1'b1;
    cyc(2);
    i_button <= 1'b0;
    cyc(10);
    av(1'b0, OMS_REG_STATUS, 32'h0);
    chk("glitch ignored", 32'h0, {30'h0, st[9:8]});
    i_button <= 1'b1;
    cyc(8);
    i_button <= 1'b0;
    cyc(10);
    av(1'b0, OMS_REG_STATUS, 32'h0);
    chk("pin press", 32'h11, {24'h0, st[6:4], 2'h0, st[9:8]});
    $display("test strap and button finished");
    wrap_up;
  end
endmodule
